// ==== spm_core.v ====
/*
  Serial peripheral port, master or slave, with four chip selects,
  per-select timing and a transmit FIFO in front of the shifter.
  Assumes one system clock, pins resolved outside from out/oe pairs,
  and software holding select settings stable during a transfer.
*/
`timescale 1ns/100ps
`default_nettype none
`include "spm_regs.vh"

module spm_core #(
  parameter DW = `SPM_DW,
  parameter DEPTH = `SPM_FIFO_DEPTH
) (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Mode settings
  input wire cfgMaster,
  input wire cfgSelMode,
  input wire cfgDecode,
  input wire cfgPrescale,
  input wire [3:0] cfgTargetSel,
  input wire [7:0] cfgGapDelay,
  // Per-select settings, lane n for select register n
  input wire [3:0] cfgPolarity,
  input wire [3:0] cfgPhase,
  input wire [31:0] cfgDivisor,
  input wire [31:0] cfgSelToClk,
  input wire [31:0] cfgInterXfer,
  // Control strobes
  input wire enableCmd,
  input wire disableCmd,
  input wire statusRead,
  input wire rxRead,
  // Transmit words
  input wire [DW-1:0] txData,
  input wire [3:0] txTarget,
  input wire txValid,
  output wire txReady,
  // Receive word and status
  output reg [DW-1:0] rxData,
  output reg [3:0] rxSelect,
  output reg rxFull,
  output reg rxOverrunFlag,
  output reg modeFaultFlag,
  output reg enabled,
  output reg busy,
  // Serial pins
  input wire sckIn,
  output reg sckOut,
  output reg sckOe,
  input wire mosiIn,
  output reg mosiOut,
  output reg mosiOe,
  input wire misoIn,
  output reg misoOut,
  output reg misoOe,
  input wire sel0In,
  output reg sel0Out,
  output reg sel0Oe,
  output reg [2:0] selHiOut,
  output reg selHiOe
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_SHIFT = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;
  localparam [2:0] ST_GAP = 3'h4;
  localparam EW = $clog2(2 * DW) + 1;
  localparam [EW-1:0] EDGE_LAST = 2 * DW - 1;
  localparam BW = $clog2(DW) + 1;
  localparam [BW-1:0] BIT_LAST = DW - 1;

  function [7:0] lane;
    input [31:0] v;
    input [1:0] i;
    begin
      lane = v[i*`SPM_LANE_W +: `SPM_LANE_W];
    end
  endfunction

  // Which select register governs a target value
  function [1:0] laneOf;
    input [3:0] t;
    input dec;
    begin
      if (dec)
        laneOf = t[3:2];
      else if (!t[0])
        laneOf = 2'h0;
      else if (!t[1])
        laneOf = 2'h1;
      else if (!t[2])
        laneOf = 2'h2;
      else
        laneOf = 2'h3;
    end
  endfunction

  // Pin synchronisers, two flops before any use
  reg [3:0] pinS1_r;
  reg [3:0] pinS2_r;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pinS1_r <= 4'hf;
      pinS2_r <= 4'hf;
    end else begin
      pinS1_r <= {sel0In, misoIn, mosiIn, sckIn};
      pinS2_r <= pinS1_r;
    end
  end
  wire sckS = pinS2_r[0];
  wire mosiS = pinS2_r[1];
  wire misoS = pinS2_r[2];
  wire sel0S = pinS2_r[3];

  // Transmit FIFO
  wire [DW+3:0] fifoData;
  wire fifoValid;
  wire fifoPop;
  spm_fifo #(.WIDTH(DW + 4), .DEPTH(DEPTH)) txFifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .inData({txTarget, txData}),
    .inValid(txValid),
    .inReady(txReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  // Master clock tick, full rate or divided by 32
  reg [4:0] preCnt_r;
  wire tick = !cfgPrescale || (preCnt_r == `SPM_PRESCALE_LAST);
  always @(posedge clk_sys) begin
    if (!rstn)
      preCnt_r <= 5'h00;
    else
      preCnt_r <= preCnt_r + 5'h01;
  end

  reg [2:0] state_r;
  reg [3:0] curSel_r;
  reg [1:0] curLane_r;
  reg [7:0] dly_r;
  reg [7:0] half_r;
  reg [EW-1:0] edge_r;
  reg [DW-1:0] txSh_r;
  reg [DW-1:0] rxSh_r;
  reg [3:0] selLines_r;
  reg pendDis_r;
  reg rxLoad_r;
  reg [DW-1:0] rxWord_r;
  reg [3:0] rxSelCap_r;
  reg [`SPM_DRV_HIST-1:0] drvHist_r;
  reg sckD_r;
  reg sel0D_r;
  reg [BW-1:0] slvCnt_r;
  reg [DW-1:0] slvTx_r;
  reg [DW-1:0] slvRx_r;

  wire isMaster = cfgMaster && enabled;
  wire isSlave = !cfgMaster && enabled;
  // Fixed target from mode settings, else from the queued word
  wire [3:0] nextSel = cfgSelMode ? fifoData[DW+3:DW] : cfgTargetSel;
  wire [1:0] nextLane = laneOf(nextSel, cfgDecode);
  wire mStart = (state_r == ST_IDLE) && isMaster && fifoValid && !pendDis_r;
  wire pol = cfgPolarity[curLane_r];
  wire pha = cfgPhase[curLane_r];
  wire [7:0] halfLen = (lane(cfgDivisor, curLane_r) < `SPM_HALF_MIN) ?
    `SPM_HALF_MIN : lane(cfgDivisor, curLane_r);
  wire [7:0] gapLen = (cfgGapDelay <= `SPM_GAP_MIN) ?
    `SPM_GAP_MIN : cfgGapDelay;
  wire halfDone = tick && (half_r + 8'h01 >= halfLen);
  wire leading = !edge_r[0];
  // Slave side edges on synchronised pins
  wire slvSel = isSlave && !sel0S;
  wire selFall = isSlave && !sel0S && sel0D_r;
  wire sckLead = slvSel && (sckS != cfgPolarity[0]) && (sckD_r == cfgPolarity[0]);
  wire sckTrail = slvSel && (sckS == cfgPolarity[0]) && (sckD_r != cfgPolarity[0]);
  wire slvCap = cfgPhase[0] ? sckLead : sckTrail;
  wire slvLaunch = cfgPhase[0] ? sckTrail : sckLead;
  wire slvDone = slvCap && (slvCnt_r == BIT_LAST);
  wire slvLoad = selFall || slvDone;
  wire mIdle = (state_r == ST_IDLE) && !(slvSel && slvCnt_r != {BW{1'b0}});
  // Fault only when nobody here pulled select0 within the sync lag
  wire fault = isMaster && !sel0S && (drvHist_r == {`SPM_DRV_HIST{1'b0}});

  assign fifoPop = mStart || (slvLoad && fifoValid);

  // Master sequencer
  always @(posedge clk_sys) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      curSel_r <= `SPM_SEL_IDLE;
      curLane_r <= 2'h0;
      dly_r <= 8'h00;
      half_r <= 8'h00;
      edge_r <= {EW{1'b0}};
      txSh_r <= {DW{1'b0}};
      rxSh_r <= {DW{1'b0}};
      selLines_r <= `SPM_SEL_IDLE;
      sckOut <= 1'b0;
      mosiOut <= 1'b0;
      rxLoad_r <= 1'b0;
      rxWord_r <= {DW{1'b0}};
      rxSelCap_r <= `SPM_SEL_IDLE;
    end else begin
      rxLoad_r <= 1'b0;
      if (fault || !cfgMaster) begin
        state_r <= ST_IDLE;
        selLines_r <= `SPM_SEL_IDLE;
        sckOut <= cfgPolarity[0];
      end else begin
        case (state_r)
          ST_IDLE: begin
            sckOut <= cfgPolarity[nextLane];
            if (mStart) begin
              curSel_r <= nextSel;
              curLane_r <= nextLane;
              selLines_r <= nextSel;
              mosiOut <= fifoData[DW-1];
              txSh_r <= fifoData[DW-1:0];
              dly_r <= 8'h00;
              state_r <= ST_SETUP;
            end
          end
          ST_SETUP: begin
            if (tick)
              dly_r <= dly_r + 8'h01;
            if (dly_r >= lane(cfgSelToClk, curLane_r)) begin
              half_r <= 8'h00;
              edge_r <= {EW{1'b0}};
              state_r <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            if (tick)
              half_r <= half_r + 8'h01;
            if (halfDone) begin
              half_r <= 8'h00;
              sckOut <= !sckOut;
              edge_r <= edge_r + 1'b1;
              if (leading == pha) begin
                rxSh_r <= {rxSh_r[DW-2:0], misoS};
              end else if (!(pha && edge_r == EDGE_LAST)) begin
                mosiOut <= pha ? txSh_r[DW-2] : txSh_r[DW-1];
                txSh_r <= pha ? {txSh_r[DW-2:0], 1'b0} : txSh_r;
              end
              if (!pha && !leading)
                txSh_r <= {txSh_r[DW-2:0], 1'b0};
              if (edge_r == EDGE_LAST) begin
                rxLoad_r <= 1'b1;
                rxWord_r <= pha ? rxSh_r :
                  {rxSh_r[DW-2:0], misoS};
                rxSelCap_r <= selLines_r;
                dly_r <= 8'h00;
                state_r <= ST_HOLD;
              end
            end
          end
          ST_HOLD: begin
            if (tick)
              dly_r <= dly_r + 8'h01;
            if (dly_r >= lane(cfgInterXfer, curLane_r)) begin
              selLines_r <= `SPM_SEL_IDLE;
              dly_r <= 8'h00;
              state_r <= ST_GAP;
            end
          end
          ST_GAP: begin
            if (tick)
              dly_r <= dly_r + 8'h01;
            if (dly_r >= gapLen)
              state_r <= ST_IDLE;
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Slave shifter, clocked by synchronised pin edges
  always @(posedge clk_sys) begin
    if (!rstn) begin
      sckD_r <= 1'b0;
      sel0D_r <= 1'b1;
      slvCnt_r <= {BW{1'b0}};
      slvTx_r <= {DW{1'b0}};
      slvRx_r <= {DW{1'b0}};
      misoOut <= 1'b0;
    end else begin
      sckD_r <= sckS;
      sel0D_r <= sel0S;
      if (!slvSel)
        slvCnt_r <= {BW{1'b0}};
      if (slvLoad) begin
        slvTx_r <= fifoValid ? fifoData[DW-1:0] : {DW{1'b0}};
        if (cfgPhase[0])
          misoOut <= fifoValid && fifoData[DW-1];
      end else if (slvLaunch) begin
        misoOut <= cfgPhase[0] ? slvTx_r[DW-2] : slvTx_r[DW-1];
        slvTx_r <= cfgPhase[0] ? {slvTx_r[DW-2:0], 1'b0} : slvTx_r;
      end
      if (slvLaunch && !cfgPhase[0] && !slvLoad)
        slvTx_r <= {slvTx_r[DW-2:0], 1'b0};
      if (slvCap) begin
        slvRx_r <= {slvRx_r[DW-2:0], mosiS};
        slvCnt_r <= slvDone ? {BW{1'b0}} : slvCnt_r + 1'b1;
      end
    end
  end

  // Enable, flags and receive register
  wire slvWord = slvDone;
  wire rxNew = rxLoad_r || slvWord;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      enabled <= 1'b0;
      pendDis_r <= 1'b0;
      rxData <= {DW{1'b0}};
      rxSelect <= `SPM_SEL_IDLE;
      rxFull <= 1'b0;
      rxOverrunFlag <= 1'b0;
      modeFaultFlag <= 1'b0;
      busy <= 1'b0;
    end else begin
      busy <= !mIdle;
      if (fault) begin
        enabled <= 1'b0;
        pendDis_r <= 1'b0;
      end else if (enableCmd && !disableCmd) begin
        enabled <= 1'b1;
        pendDis_r <= 1'b0;
      end else if (disableCmd || pendDis_r) begin
        // Running word completes before the port drops
        if (mIdle) begin
          enabled <= 1'b0;
          pendDis_r <= 1'b0;
        end else begin
          pendDis_r <= 1'b1;
        end
      end
      if (fault)
        modeFaultFlag <= 1'b1;
      else if (statusRead)
        modeFaultFlag <= 1'b0;
      if (rxNew && rxFull && !(rxRead))
        rxOverrunFlag <= 1'b1;
      else if (statusRead)
        rxOverrunFlag <= 1'b0;
      if (rxNew) begin
        rxFull <= 1'b1;
        rxData <= slvWord ? {slvRx_r[DW-2:0], mosiS} : rxWord_r;
        rxSelect <= slvWord ? `SPM_SEL_IDLE : rxSelCap_r;
      end else if (rxRead) begin
        rxFull <= 1'b0;
      end
    end
  end

  // Pin drivers
  always @(posedge clk_sys) begin
    if (!rstn) begin
      sckOe <= 1'b0;
      mosiOe <= 1'b0;
      misoOe <= 1'b0;
      sel0Out <= 1'b0;
      sel0Oe <= 1'b0;
      selHiOut <= 3'h7;
      selHiOe <= 1'b0;
      drvHist_r <= {`SPM_DRV_HIST{1'b0}};
    end else begin
      sckOe <= isMaster;
      mosiOe <= isMaster;
      misoOe <= slvSel;
      // Select0 is open drain so an outside master can pull it
      sel0Out <= 1'b0;
      sel0Oe <= isMaster && !selLines_r[0];
      selHiOut <= selLines_r[3:1];
      selHiOe <= isMaster;
      drvHist_r <= {drvHist_r[`SPM_DRV_HIST-2:0], sel0Oe};
    end
  end
endmodule // spm_core

`default_nettype wire

// ==== spm_core_chk.sv ====
/*
  Port checker for spm_core: pin drive by mode, idle selects, sticky flags.
  Assumes binding onto spm_core and a single system clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module spm_core_chk #(
  parameter DW = 16,
  parameter DEPTH = 16
) (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Mode, strobes and select0 pin
  input wire cfgMaster,
  input wire statusRead,
  input wire sel0In,
  // Status
  input wire busy,
  input wire enabled,
  input wire rxFull,
  input wire rxOverrunFlag,
  input wire modeFaultFlag,
  input wire [3:0] rxSelect,
  // Pin drives
  input wire sckOe,
  input wire mosiOe,
  input wire misoOe,
  input wire sel0Oe,
  input wire [2:0] selHiOut,
  input wire selHiOe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_slave_quiet: assert property (!cfgMaster && $past(!cfgMaster) |->
    !selHiOe && !sckOe && !mosiOe) else $error("master pins in slave mode");
  a_miso_master: assert property (cfgMaster && $past(cfgMaster) |->
    !misoOe) else $error("miso driven in master mode");
  a_idle_high: assert property (!busy && $past(!busy) |->
    selHiOut == 3'h7 && !sel0Oe) else $error("select low while idle");
  a_fault_off: assert property ($rose(modeFaultFlag) |->
    !enabled && selHiOut == 3'h7) else $error("port alive after fault");
  a_fault_hold: assert property (modeFaultFlag && !statusRead |=>
    modeFaultFlag) else $error("fault flag lost");
  a_fault_cause: assert property ($rose(modeFaultFlag) |->
    $past(enabled && cfgMaster) && !$past(sel0In))
    else $error("fault without low select");
  a_ovr_hold: assert property (rxOverrunFlag && !statusRead |=>
    rxOverrunFlag) else $error("overrun flag lost");
  a_ovr_cause: assert property ($rose(rxOverrunFlag) |->
    $past(rxFull)) else $error("overrun without unread word");
  a_rx_sel: assert property (cfgMaster && $rose(rxFull) |->
    rxSelect != 4'hf) else $error("no select captured");
  a_rx_busy: assert property ($rose(rxFull) |->
    $past(busy)) else $error("word without transfer");
endmodule // spm_core_chk

bind spm_core spm_core_chk #(.DW(DW), .DEPTH(DEPTH)) spm_core_chk_inst (
  .clk_sys(clk_sys), .rstn(rstn), .cfgMaster(cfgMaster),
  .statusRead(statusRead), .sel0In(sel0In), .busy(busy), .enabled(enabled),
  .rxFull(rxFull), .rxOverrunFlag(rxOverrunFlag),
  .modeFaultFlag(modeFaultFlag), .rxSelect(rxSelect), .sckOe(sckOe),
  .mosiOe(mosiOe), .misoOe(misoOe), .sel0Oe(sel0Oe), .selHiOut(selHiOut),
  .selHiOe(selHiOe));

`default_nettype wire

// ==== spm_core_tb_top.sv ====
/*
  Self-checking bench: spm_core as master against a slave model.
  Assumes spm_core, spm_fifo and spm_slave_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module spm_core_tb_top;
  logic clk_sys = 0, rstn = 0, cfgMaster = 0, cfgSelMode = 0, cfgDecode = 0;
  logic [3:0] cfgTargetSel = 4'he, txTarget = 4'h0;
  logic [7:0] cfgGapDelay = 8'h00;
  logic [31:0] cfgDivisor = 32'h03030303, cfgSelToClk = 0, cfgInterXfer = 0;
  logic enableCmd = 0, disableCmd = 0, statusRead = 0, rxRead = 0;
  logic txValid = 0, extLow = 0, readEn = 1, watch = 1, selPrev = 0;
  logic [15:0] txData = 0, respWord = 0;
  logic [31:0] seed = 35090;
  logic [15:0] sentQ[$], expRx[$];
  logic [3:0] expSel[$];
  integer n_fail = 0, checks_done = 0;
  wire txReady, rxFull, rxOverrunFlag, modeFaultFlag, enabled, busy;
  wire sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, sel0Out, sel0Oe;
  wire selHiOe, slaveMiso, sckPin, mosiPin, misoPin, sel0Pin, anySel;
  wire [15:0] rxData, gotWord;
  wire [3:0] rxSelect, selPins;
  wire [2:0] selHiOut;
  // Open-drain select0 with pull-up; extLow plays a foreign master
  assign sel0Pin = !((sel0Oe && !sel0Out) || extLow);
  assign selPins = {selHiOe ? selHiOut : 3'h7, sel0Pin};
  assign anySel = (selPins != 4'hf);
  assign sckPin = sckOe & sckOut;
  assign mosiPin = mosiOe & mosiOut;
  assign misoPin = misoOe ? misoOut : slaveMiso;

  spm_core #(.DW(16), .DEPTH(16)) spm_core_inst (
    .clk_sys(clk_sys), .rstn(rstn), .cfgMaster(cfgMaster),
    .cfgSelMode(cfgSelMode), .cfgDecode(cfgDecode), .cfgPrescale(1'b0),
    .cfgTargetSel(cfgTargetSel), .cfgGapDelay(cfgGapDelay),
    .cfgPolarity(4'h0), .cfgPhase(4'hf), .cfgDivisor(cfgDivisor),
    .cfgSelToClk(cfgSelToClk), .cfgInterXfer(cfgInterXfer),
    .enableCmd(enableCmd), .disableCmd(disableCmd), .statusRead(statusRead),
    .rxRead(rxRead), .txData(txData), .txTarget(txTarget),
    .txValid(txValid), .txReady(txReady), .rxData(rxData),
    .rxSelect(rxSelect), .rxFull(rxFull), .rxOverrunFlag(rxOverrunFlag),
    .modeFaultFlag(modeFaultFlag), .enabled(enabled), .busy(busy),
    .sckIn(sckPin), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiPin),
    .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoPin),
    .misoOut(misoOut), .misoOe(misoOe), .sel0In(sel0Pin),
    .sel0Out(sel0Out), .sel0Oe(sel0Oe), .selHiOut(selHiOut),
    .selHiOe(selHiOe));

  spm_slave_model spm_slave_model_inst (.sck(sckPin), .mosi(mosiPin),
    .selPins(selPins), .miso(slaveMiso), .respWord(respWord),
    .gotWord(gotWord));

  initial forever #4 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One-cycle command pulse: 0 enable, 1 status read, 2 disable
  task strobe(input int which);
    @(posedge clk_sys);
    case (which)
      0: enableCmd <= 1;
      1: statusRead <= 1;
      default: disableCmd <= 1;
    endcase
    @(posedge clk_sys);
    enableCmd <= 0;
    statusRead <= 0;
    disableCmd <= 0;
  endtask

  task send(input logic [3:0] tgt);
    logic [15:0] d;
    logic [15:0] r;
    d = rnd();
    r = rnd();
    @(posedge clk_sys);
    sentQ.push_back(d);
    expRx.push_back(r);
    expSel.push_back(cfgSelMode ? tgt : cfgTargetSel);
    if (expRx.size() == 1) respWord = r;
    txData <= d;
    txTarget <= tgt;
    txValid <= 1;
    do @(posedge clk_sys); while (txReady !== 1'b1);
    txValid <= 0;
  endtask

  task drain;
    int k;
    for (k = 0; k < 4000 && (expRx.size() != 0 || busy !== 1'b0); k++)
      @(posedge clk_sys);
    // A transfer that never ends is a failure, not a pass
    if (k >= 4000) begin
      n_fail++;
      $display("drain limit reached");
    end
  endtask

  // Reference model: one word checked at every deselect while watch is set
  always @(posedge clk_sys) begin
    selPrev <= anySel;
    rxRead <= 0;
    if (watch && selPrev && !anySel && expRx.size() != 0) begin
      check("rxData", rxData, expRx.pop_front());
      check("rxSelect", rxSelect, expSel.pop_front());
      check("mosi word", gotWord, sentQ.pop_front());
      check("rxFull", rxFull, 1);
      rxRead <= readEn;
      respWord <= (expRx.size() != 0) ? expRx[0] : 16'h0000;
    end
  end

  initial begin
    int i;
    logic [15:0] vtab;
    vtab = 16'ha57d;
    repeat (12) @(posedge clk_sys);
    rstn <= 1;
    repeat (2) @(posedge clk_sys);
    check("idle", {enabled, rxOverrunFlag, modeFaultFlag, selHiOe, sckOe,
      misoOe, rxSelect, selHiOut}, {6'h00, 4'hf, 3'h7});
    $display("test reset done");
    cfgMaster <= 1;
    strobe(0);
    for (i = 0; i < 4; i++) begin
      // Target changes only with the port drained
      cfgTargetSel <= 4'hf ^ (4'h1 << i);
      cfgSelToClk <= rnd() & 32'h07070707;
      cfgInterXfer <= rnd() & 32'h07070707;
      cfgDivisor <= (rnd() & 32'h01010101) + 32'h03030303;
      cfgGapDelay <= rnd() & 8'h0f;
      repeat (3) send(4'h0);
      drain;
    end
    $display("test fixed select done");
    cfgSelMode <= 1;
    for (i = 0; i < 4; i++) begin
      if (i == 2) begin
        drain;
        cfgDecode <= 1;
      end
      send(vtab[4*i +: 4]);
    end
    drain;
    $display("test variable select done");
    cfgSelMode <= 0;
    cfgDecode <= 0;
    readEn <= 0;
    send(4'h0);
    send(4'h0);
    drain;
    check("overrun", rxOverrunFlag, 1);
    strobe(1);
    @(posedge clk_sys);
    check("overrun cleared", rxOverrunFlag, 0);
    readEn <= 1;
    $display("test overrun done");
    watch <= 0;
    extLow <= 1;
    for (i = 0; i < 20 && modeFaultFlag !== 1'b1; i++) @(posedge clk_sys);
    @(posedge clk_sys);
    check("fault", {modeFaultFlag, enabled, selHiOut}, 5'h17);
    extLow <= 0;
    repeat (4) @(posedge clk_sys);
    check("fault held", {modeFaultFlag, enabled}, 2'h2);
    strobe(1);
    @(posedge clk_sys);
    check("fault cleared", modeFaultFlag, 0);
    strobe(0);
    @(posedge clk_sys);
    check("enabled", enabled, 1);
    watch <= 1;
    send(4'h0);
    drain;
    $display("test mode fault done");
    strobe(2);
    repeat (2) @(posedge clk_sys);
    check("off", {enabled, sckOe, selHiOe}, 0);
    cfgMaster <= 0;
    repeat (4) @(posedge clk_sys);
    $display("test disable done");
    report_and_stop;
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    n_fail++;
    $display("watchdog expired");
    report_and_stop;
  end
endmodule // spm_core_tb_top

`default_nettype wire

// ==== spm_fifo.v ====
/*
  Transmit word FIFO with a registered read stage.
  Assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module spm_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 16
) (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Fill side
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output reg inReady,
  // Drain side
  output reg [WIDTH-1:0] outData,
  output reg outValid,
  input wire outReady
);
  localparam AW = $clog2(DEPTH);
  localparam [AW:0] FULL = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] count_r;
  reg [AW:0] count_nxt;
  wire push = inValid && inReady;
  // Refill the output stage whenever it is empty or being drained
  wire pull = (count_r != {(AW+1){1'b0}}) && (!outValid || outReady);

  always @* begin
    count_nxt = count_r;
    if (push && !pull)
      count_nxt = count_r + 1'b1;
    else if (!push && pull)
      count_nxt = count_r - 1'b1;
  end

  always @(posedge clk_sys) begin
    if (push)
      mem[wrPtr_r] <= inData;
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      inReady <= 1'b0;
      outValid <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end else begin
      count_r <= count_nxt;
      inReady <= (count_nxt != FULL);
      if (push)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (pull) begin
        outData <= mem[rdPtr_r];
        outValid <= 1'b1;
        rdPtr_r <= rdPtr_r + 1'b1;
      end else if (outReady) begin
        outValid <= 1'b0;
      end
    end
  end
endmodule // spm_fifo

`default_nettype wire

// ==== spm_regs.vh ====
/*
  Constants for the serial peripheral port: widths, lane layout of the
  per-select configuration ports, delay floors and idle levels.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SPM_REGS_VH
`define SPM_REGS_VH

// Word and select widths, transmit FIFO depth
`define SPM_DW 16
`define SPM_SEL_W 4
`define SPM_FIFO_DEPTH 16

// Per-select configuration lanes, one byte per select register
`define SPM_LANE_W 8
`define SPM_LANES 4

// Half-period floor: divisors below 2 still give two master clocks per half period
`define SPM_HALF_MIN 8'h02
// Floor of the gap between deselect and next select
`define SPM_GAP_MIN 8'h06
// Prescaler for the slow master clock, divide by 32
`define SPM_PRESCALE_LAST 5'h1f

// All select lines high: no peripheral selected
`define SPM_SEL_IDLE 4'hf
// History depth covering the input synchroniser lag
`define SPM_DRV_HIST 3

`endif

// ==== spm_slave_model.sv ====
/*
  Slave peripheral model on the far side of the serial pins.
  Assumes idle-low clock, capture on the rising edge, MSB first.
*/
`timescale 1ns/100ps
`default_nettype none

module spm_slave_model (
  // Serial side
  input wire logic sck,
  input wire logic mosi,
  input wire logic [3:0] selPins,
  output logic miso,
  // Bench side
  input wire logic [15:0] respWord,
  output logic [15:0] gotWord
);
  logic [15:0] shiftR = 16'h0000;
  logic sel;
  assign sel = (selPins != 4'hf);
  initial miso = 1'b0;
  initial gotWord = 16'h0000;
  // First bit must stand before the first capture edge
  always @(posedge sel) begin
    shiftR = respWord;
    miso = respWord[15];
  end
  always @(posedge sck) begin
    if (sel) gotWord = {gotWord[14:0], mosi};
  end
  always @(negedge sck) begin
    if (sel) begin
      shiftR = {shiftR[14:0], 1'b0};
      miso = shiftR[15];
    end
  end
  // No pull on this line: show the inverse rather than a held bit
  always @(negedge sel) miso = ~miso;
endmodule // spm_slave_model

`default_nettype wire
